// file: serial_pkg.sv
// Shared offsets, field positions, reset values and states of the serial block
package serial_pkg;
    localparam logic [7:0] FMT_OFS = 8'h00;
    localparam logic [7:0] TXB_OFS = 8'h04;
    localparam logic [7:0] RXB_OFS = 8'h08;
    localparam logic [7:0] CTL_OFS = 8'h0C;
    localparam logic [7:0] FLG_OFS = 8'h10;
    localparam logic [7:0] RATE_OFS = 8'h14;
    localparam int FMT_SYNC = 7;
    localparam int FMT_CHR7 = 6;
    localparam int FMT_PAR_EN = 5;
    localparam int FMT_ODD = 4;
    localparam int FMT_STOP2 = 3;
    localparam int FMT_MP = 2;
    localparam int FMT_CKS_HI = 1;
    localparam int FMT_CKS_LO = 0;
    localparam int CTL_TX_EN = 0;
    localparam int CTL_RX_EN = 1;
    localparam int CTL_MPB = 2;
    localparam int FLG_TX_BUFFER_EMPTY_FLAG = 0;
    localparam int FLG_RDRF = 1;
    localparam int FLG_FER = 2;
    localparam int FLG_PER = 3;
    localparam int FLG_MPB = 4;
    localparam int FLG_TEND = 5;
    localparam logic [7:0] FMT_RST = 8'h00;
    localparam logic [7:0] TXB_RST = 8'hFF;
    localparam logic [7:0] RXB_RST = 8'h00;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [4:0] FLG_RST = 5'h01;
    localparam logic [7:0] RATE_RST = 8'hFF;
    localparam logic [5:0] PRE_DIV1 = 6'h00;
    localparam logic [5:0] PRE_DIV4 = 6'h03;
    localparam logic [5:0] PRE_DIV16 = 6'h0F;
    localparam logic [5:0] PRE_DIV64 = 6'h3F;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_START = 3'b001,
        TX_DATA = 3'b010,
        TX_PAR = 3'b011,
        TX_STOP = 3'b100
    } tx_state_t;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PAR = 3'b011,
        RX_STOP = 3'b100
    } rx_state_t;
endpackage

// file: serial_prescaler.sv
// Baud generator input clock prescaler: system clock divided by 1, 4, 16 or 64
`timescale 1ns/1ps
module serial_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] cks,
    output logic tick
);
    logic [5:0] cnt;
    logic [5:0] limit;

    assign limit = (cks == 2'b00) ? serial_pkg::PRE_DIV1 :
                   (cks == 2'b01) ? serial_pkg::PRE_DIV4 :
                   (cks == 2'b10) ? serial_pkg::PRE_DIV16 :
                   serial_pkg::PRE_DIV64;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 6'h00;
            tick <= 1'b0;
        end else begin
            tick <= (cnt >= limit);
            cnt <= (cnt >= limit) ? 6'h00 : cnt + 6'h01;
        end
    end

    a_tick_div16: assert property (@(posedge pclk) disable iff (!presetn)
        tick && cks == 2'b10 && $stable(cks) |=> !tick [*8])
        else $error("prescaler tick too early at divide by 16");
endmodule

// file: serial_core.sv
// Serial data path and frame format with its APB register file
// Summary of operation
// - Receiver shifts serial bits into its shifter, least significant first
// - Full character moves to receive buffer; shifter is free at once
// - Receive buffer is read only; writes do not change it
// - Receive buffer and format register clear on reset and low power
// - Transmit buffer sets to all ones on reset and low power
// - Buffer byte goes to transmit shifter, sent least significant first
// - Next byte loads after each character, never while empty flag set
// - Transmit buffer and format always accessible; shifters never reachable (writes to both are dropped while low_power_stop is high)
// - Format bit 7 picks asynchronous (0) or synchronous (1) mode
// - Format bit 6 picks 8 or 7 bits; synchronous always 8
// - Seven-bit characters never send buffer bit 7
// - Format bit 5 enables parity only in plain asynchronous mode
// - Format bit 4 picks even (0) or odd (1) parity
// - Format bit 3 appends one or two high stop bits
// - Receiver checks first stop bit; low second stop starts next character
// - Synchronous mode adds no stop bits; stop length ignored
// - Format bit 2 picks multiprocessor format over parity, async only
// - Format bits 1:0 select prescale 1, 4, 16 or 64
// - Sending starts once enabled and buffer empty flag is cleared
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module serial_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_power_stop,
    input wire logic rxd,
    output logic txd,
    output logic sclk_out
);
    logic [7:0] serial_format_reg;
    logic [7:0] transmit_buffer_reg;
    logic [7:0] receive_buffer_reg;
    logic [7:0] ctrl;
    logic [7:0] rate;
    logic [4:0] flags;
    logic [7:0] transmit_shifter;
    logic [7:0] receive_shifter;
    logic [7:0] rx_char;
    logic rx_par;
    logic tx_extra;
    logic [2:0] tx_bitn;
    logic [2:0] rx_bitn;
    logic tx_stopn;
    logic [7:0] tx_cnt;
    logic [7:0] rx_cnt;
    logic rx_s1;
    logic rx_s2;
    logic rx_prev;
    logic tick;
    serial_pkg::tx_state_t tx_state;
    serial_pkg::rx_state_t rx_state;

    serial_prescaler u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .cks(serial_format_reg[serial_pkg::FMT_CKS_HI:serial_pkg::FMT_CKS_LO]),
        .tick(tick)
    );

    // Format decode
    wire sync = serial_format_reg[serial_pkg::FMT_SYNC];
    wire chr7 = serial_format_reg[serial_pkg::FMT_CHR7] & ~sync;
    wire mp_on = serial_format_reg[serial_pkg::FMT_MP] & ~sync;
    wire par_on = serial_format_reg[serial_pkg::FMT_PAR_EN] & ~sync
        & ~serial_format_reg[serial_pkg::FMT_MP];
    wire odd = serial_format_reg[serial_pkg::FMT_ODD];
    wire stop2 = serial_format_reg[serial_pkg::FMT_STOP2] & ~sync;
    wire [2:0] last_bit = chr7 ? 3'h6 : 3'h7;
    wire [7:0] half = {1'b0, rate[7:1]};
    wire tx_en = ctrl[serial_pkg::CTL_TX_EN];
    wire rx_en = ctrl[serial_pkg::CTL_RX_EN];
    wire tx_buffer_empty_flag = flags[serial_pkg::FLG_TX_BUFFER_EMPTY_FLAG];

    // APB decode; commit at the edge where the master sees pready
    wire access = psel & penable & ~pready;
    wire commit = psel & penable & pready;
    wire wr = commit & pwrite;
    wire hit_fmt = paddr == serial_pkg::FMT_OFS;
    wire hit_txb = paddr == serial_pkg::TXB_OFS;
    wire hit_rxb = paddr == serial_pkg::RXB_OFS;
    wire hit_ctl = paddr == serial_pkg::CTL_OFS;
    wire hit_flg = paddr == serial_pkg::FLG_OFS;
    wire hit_rate = paddr == serial_pkg::RATE_OFS;
    wire mapped = hit_fmt | hit_txb | hit_rxb | hit_ctl | hit_flg | hit_rate;
    wire tend = tx_buffer_empty_flag & (tx_state == serial_pkg::TX_IDLE);
    // Shifters have no address at all
    wire [7:0] rd_byte = hit_fmt ? serial_format_reg :
                         hit_txb ? transmit_buffer_reg :
                         hit_rxb ? receive_buffer_reg :
                         hit_ctl ? ctrl :
                         hit_flg ? {2'b00, tend, flags} :
                         hit_rate ? rate : 8'h00;

    // Transmit timing
    wire tx_bit_end = tick & (tx_cnt == rate);
    wire tx_last = tx_bitn == last_bit;
    wire tx_frame_end = tx_bit_end
        & ((tx_state == serial_pkg::TX_DATA & tx_last & sync)
        | (tx_state == serial_pkg::TX_STOP & (~stop2 | tx_stopn)));
    wire tx_load = tx_en & ~tx_buffer_empty_flag
        & (tx_state == serial_pkg::TX_IDLE | tx_frame_end);
    wire [7:0] tx_mask = {~chr7, 7'h7F};
    wire tx_par = (^(transmit_buffer_reg & tx_mask)) ^ odd;
    wire sample_sync = sync & rx_en & tick & (tx_cnt == half)
        & (tx_state == serial_pkg::TX_DATA);

    // Receive timing
    wire rx_fall = rx_prev & ~rx_s2;
    wire rx_half = tick & (rx_cnt == half);
    wire rx_bit_end = tick & (rx_cnt == rate);
    wire rx_start_ok = (rx_state == serial_pkg::RX_START) & rx_half & ~rx_s2;
    wire async_done = (rx_state == serial_pkg::RX_STOP) & rx_bit_end;
    wire sync_done = sample_sync & (tx_bitn == 3'h7);
    wire rx_done = async_done | sync_done;
    wire [7:0] rx_shift_in = {rx_s2, receive_shifter[7:1]};
    wire [7:0] rx_word = sync ? rx_shift_in : rx_char;
    wire par_bad = (^{rx_char, rx_par}) != odd;

    // Flags: hardware set wins over a software clear
    wire [4:0] flg_clr = (wr & hit_flg) ? ~pwdata[4:0] : 5'h00;
    wire [4:0] flg_set = {async_done & mp_on & rx_par,
                          async_done & par_on & par_bad,
                          async_done & ~rx_s2,
                          rx_done, tx_load};
    wire [4:0] next_flags = ((flags & ~flg_clr) | flg_set)
        | {4'h0, ~tx_en};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access;
            pslverr <= access & ~mapped;
            prdata <= (access & ~pwrite) ? {24'h000000, rd_byte} : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_format_reg <= serial_pkg::FMT_RST;
            transmit_buffer_reg <= serial_pkg::TXB_RST;
            ctrl <= serial_pkg::CTL_RST;
            rate <= serial_pkg::RATE_RST;
            flags <= serial_pkg::FLG_RST;
        end else if (low_power_stop) begin
            serial_format_reg <= serial_pkg::FMT_RST;
            transmit_buffer_reg <= serial_pkg::TXB_RST;
            ctrl <= serial_pkg::CTL_RST;
            flags <= serial_pkg::FLG_RST;
        end else begin
            if (wr & hit_fmt) serial_format_reg <= pwdata[7:0];
            if (wr & hit_txb) transmit_buffer_reg <= pwdata[7:0];
            if (wr & hit_ctl) ctrl <= {5'h00, pwdata[2:0]};
            if (wr & hit_rate) rate <= pwdata[7:0];
            flags <= next_flags;
        end
    end

    // No write path: only the receiver loads it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_buffer_reg <= serial_pkg::RXB_RST;
        end else if (low_power_stop) begin
            receive_buffer_reg <= serial_pkg::RXB_RST;
        end else if (rx_done) begin
            receive_buffer_reg <= rx_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt <= 8'h00;
        end else if (tx_state == serial_pkg::TX_IDLE || tx_load) begin
            tx_cnt <= 8'h00;
        end else if (tick) begin
            tx_cnt <= (tx_cnt == rate) ? 8'h00 : tx_cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= serial_pkg::TX_IDLE;
            transmit_shifter <= 8'h00;
            tx_bitn <= 3'h0;
            tx_stopn <= 1'b0;
            tx_extra <= 1'b0;
        end else if (low_power_stop) begin
            tx_state <= serial_pkg::TX_IDLE;
        end else if (tx_load) begin
            transmit_shifter <= transmit_buffer_reg;
            tx_extra <= mp_on ? ctrl[serial_pkg::CTL_MPB] : tx_par;
            tx_bitn <= 3'h0;
            tx_stopn <= 1'b0;
            tx_state <= sync ? serial_pkg::TX_DATA
                             : serial_pkg::TX_START;
        end else if (tx_frame_end) begin
            tx_state <= serial_pkg::TX_IDLE;
        end else if (tx_bit_end) begin
            case (tx_state)
                serial_pkg::TX_START: begin
                    tx_state <= serial_pkg::TX_DATA;
                end
                serial_pkg::TX_DATA: begin
                    transmit_shifter <= {1'b0, transmit_shifter[7:1]};
                    tx_bitn <= tx_bitn + 3'h1;
                    if (tx_last) begin
                        tx_state <= (par_on | mp_on) ? serial_pkg::TX_PAR
                                                     : serial_pkg::TX_STOP;
                    end
                end
                serial_pkg::TX_PAR: begin
                    tx_state <= serial_pkg::TX_STOP;
                end
                serial_pkg::TX_STOP: begin
                    tx_stopn <= 1'b1;
                end
                default: begin
                    tx_state <= serial_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // Pins lag the state by one clock, negligible against a bit time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd <= 1'b1;
            sclk_out <= 1'b1;
        end else begin
            case (tx_state)
                serial_pkg::TX_START: txd <= 1'b0;
                serial_pkg::TX_DATA: txd <= transmit_shifter[0];
                serial_pkg::TX_PAR: txd <= tx_extra;
                default: txd <= 1'b1;
            endcase
            sclk_out <= ~(sync & (tx_state == serial_pkg::TX_DATA)
                & (tx_cnt < half));
        end
    end

    // Logic reads the second and third flops (rx_s2, rx_prev), never the first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_s1 <= rxd;
            rx_s2 <= rx_s1;
            rx_prev <= rx_s2;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt <= 8'h00;
        end else if (rx_state == serial_pkg::RX_IDLE || rx_start_ok) begin
            rx_cnt <= 8'h00;
        end else if (tick) begin
            rx_cnt <= (rx_cnt == rate) ? 8'h00 : rx_cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= serial_pkg::RX_IDLE;
            receive_shifter <= 8'h00;
            rx_char <= 8'h00;
            rx_bitn <= 3'h0;
            rx_par <= 1'b0;
        end else if (low_power_stop) begin
            rx_state <= serial_pkg::RX_IDLE;
        end else if (sample_sync) begin
            receive_shifter <= rx_shift_in;
        end else begin
            case (rx_state)
                serial_pkg::RX_IDLE: begin
                    rx_bitn <= 3'h0;
                    if (rx_en & ~sync & rx_fall) begin
                        rx_state <= serial_pkg::RX_START;
                    end
                end
                serial_pkg::RX_START: begin
                    if (rx_half) begin
                        rx_state <= rx_s2 ? serial_pkg::RX_IDLE
                                          : serial_pkg::RX_DATA;
                    end
                end
                serial_pkg::RX_DATA: begin
                    if (rx_bit_end) begin
                        receive_shifter <= rx_shift_in;
                        rx_bitn <= rx_bitn + 3'h1;
                        if (rx_bitn == last_bit) begin
                            rx_char <= chr7 ? {1'b0, rx_shift_in[7:1]}
                                            : rx_shift_in;
                            rx_state <= (par_on | mp_on)
                                ? serial_pkg::RX_PAR : serial_pkg::RX_STOP;
                        end
                    end
                end
                serial_pkg::RX_PAR: begin
                    if (rx_bit_end) begin
                        rx_par <= rx_s2;
                        rx_state <= serial_pkg::RX_STOP;
                    end
                end
                serial_pkg::RX_STOP: begin
                    // Idle after first stop so a low second stop is a start
                    if (rx_bit_end) rx_state <= serial_pkg::RX_IDLE;
                end
                default: rx_state <= serial_pkg::RX_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_tx_begin;
        tx_state == serial_pkg::TX_IDLE ##1 tx_state == serial_pkg::TX_START;
    endsequence

    a_start_low: assert property (s_tx_begin |=> !txd)
        else $error("start bit not driven low");
    a_stop_high: assert property (
        tx_state == serial_pkg::TX_STOP |=> txd)
        else $error("stop bit not high");
    a_sync_no_stop: assert property (sync && !$rose(sync) |->
        tx_state != serial_pkg::TX_STOP
        && tx_state != serial_pkg::TX_START)
        else $error("stop or start bit in synchronous mode");
    a_load_copy: assert property (tx_load && !low_power_stop |=>
        transmit_shifter == $past(transmit_buffer_reg) && tx_buffer_empty_flag)
        else $error("shifter not loaded from buffer");
    a_hold_empty: assert property (tx_state == serial_pkg::TX_IDLE
        && tx_buffer_empty_flag && !low_power_stop |=>
        tx_state == serial_pkg::TX_IDLE)
        else $error("transmit started with empty buffer");
    a_rx_readonly: assert property (wr && hit_rxb && !rx_done
        && !low_power_stop |=> $stable(receive_buffer_reg))
        else $error("receive buffer changed by a write");
    a_rx_transfer: assert property (rx_done && !low_power_stop |=>
        receive_buffer_reg == $past(rx_word))
        else $error("received character not transferred");
    a_lp_clear: assert property (low_power_stop |=>
        serial_format_reg == 8'h00 && receive_buffer_reg == 8'h00
        && transmit_buffer_reg == 8'hFF)
        else $error("low power did not reset the registers");
endmodule

// file: serial_peer.sv
// Remote serial peer: drives the receive line, captures transmit frames
`timescale 1ns/1ps
module serial_peer (
    input wire logic pclk,
    input wire logic txd,
    input wire logic sclk_out,
    output logic rxd
);
    // Line idles high, as a pulled-up pin would
    initial rxd = 1'b1;

    // Bit time in pclk cycles sets a prompt or a slow peer
    task automatic send(input logic [31:0] v, input int n, input int bt);
        for (int i = 0; i < n; i++) begin
            rxd <= v[i];
            repeat (bt) @(posedge pclk);
        end
        rxd <= 1'b1;
    endtask

    task automatic grab(input logic sy, input int n, input int bt,
                        output logic [15:0] v);
        v = 16'h0000;
        if (!sy) begin
            @(negedge txd);
            repeat (bt / 2) @(posedge pclk);
        end
        for (int i = 0; i < n; i++) begin
            if (sy) begin
                @(posedge sclk_out);
            end else if (i > 0) begin
                repeat (bt) @(posedge pclk);
            end
            v[i] = txd;
        end
    endtask
endmodule

// file: tb_serial_datapath_and_format.sv
// Self-checking bench for the serial data path and frame format
`timescale 1ns/1ps
module tb_serial_datapath_and_format;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic low_power_stop = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rxd;
    logic txd;
    logic sclk_out;
    logic last_err;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    // Entries: format, control, rate, data
    localparam logic [31:0] tx_table [10] = '{
        32'h000103A5,
        32'h400103FF,
        32'h20010307,
        32'h30010307,
        32'h0801035A,
        32'h240503C3,
        32'hEC030396,
        32'h01010F96,
        32'h02010396,
        32'h03010196
    };

    always #25 pclk = ~pclk;

    serial_core dut_u (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .low_power_stop(low_power_stop),
        .rxd(rxd),
        .txd(txd),
        .sclk_out(sclk_out)
    );

    serial_peer peer_u (
        .pclk(pclk),
        .txd(txd),
        .sclk_out(sclk_out),
        .rxd(rxd)
    );

    task automatic report_and_stop;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Idle cycle after release keeps psel from being set twice per step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, a, {24'h000000, d}, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h00000000, r);
        check(r, e);
    endtask

    task automatic poll(input int b);
        logic [31:0] r;
        int k;
        k = 0;
        r = 32'h00000000;
        while (r[b] !== 1'b1 && k < 1000) begin
            apb(1'b0, serial_pkg::FLG_OFS, 32'h00000000, r);
            k++;
        end
        check({31'h00000000, r[b]}, 32'h00000001);
    endtask

    function automatic void add(inout logic [15:0] v, inout int n,
                                input logic b);
        v[n] = b;
        n = n + 1;
    endfunction

    // Expected line bits, first on the wire in bit 0, plus next first bit
    function automatic int mk(input logic [7:0] f, input logic [7:0] c,
                              input logic [7:0] d, output logic [15:0] v);
        int n;
        logic [7:0] m;
        n = 0;
        v = 16'h0000;
        m = (f[6] && !f[7]) ? 8'h7F : 8'hFF;
        if (!f[7]) add(v, n, 1'b0);
        for (int i = 0; i < (m[7] ? 8 : 7); i++) add(v, n, d[i]);
        if (!f[7] && f[2]) add(v, n, c[2]);
        else if (!f[7] && f[5]) add(v, n, ^(d & m) ^ f[4]);
        if (!f[7]) add(v, n, 1'b1);
        if (!f[7] && f[3]) add(v, n, 1'b1);
        add(v, n, 1'b0);
        return n;
    endfunction

    task automatic tx_case(input logic [31:0] t);
        logic [15:0] v;
        logic [15:0] got;
        int n;
        int bt;
        n = mk(t[31:24], t[23:16], t[7:0], v);
        bt = (t[15:8] + 1) << (2 * t[25:24]);
        wr(serial_pkg::FMT_OFS, t[31:24]);
        wr(serial_pkg::RATE_OFS, t[15:8]);
        wr(serial_pkg::CTL_OFS, t[23:16]);
        fork
            peer_u.grab(t[31], n, bt, got);
            begin
                wr(serial_pkg::TXB_OFS, t[7:0]);
                wr(serial_pkg::FLG_OFS, 8'h00);
                poll(serial_pkg::FLG_TX_BUFFER_EMPTY_FLAG);
                wr(serial_pkg::TXB_OFS, 8'h00);
                wr(serial_pkg::FLG_OFS, 8'h00);
            end
        join
        check({16'h0000, got}, {16'h0000, v});
        poll(serial_pkg::FLG_TEND);
    endtask

    task automatic rx_case(input logic [7:0] fd, input logic [7:0] fs,
                           input logic [7:0] d, input logic [7:0] fl);
        logic [15:0] v;
        logic [31:0] r;
        int n;
        n = mk(fs, 8'h00, d, v);
        wr(serial_pkg::FMT_OFS, fd);
        wr(serial_pkg::RATE_OFS, 8'h03);
        wr(serial_pkg::CTL_OFS, 8'h02);
        wr(serial_pkg::FLG_OFS, 8'h00);
        peer_u.send({16'h0000, v}, n - 1, 4);
        poll(serial_pkg::FLG_RDRF);
        apb(1'b0, serial_pkg::FLG_OFS, 32'h00000000, r);
        check(r & 32'h0000000E, {24'h000000, fl});
        r = {24'h000000, d & (fd[6] ? 8'h7F : 8'hFF)};
        rd(serial_pkg::RXB_OFS, r);
    endtask

    initial begin
        logic [15:0] v;
        logic [15:0] w;
        logic [31:0] r;
        int n;
        int k;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(serial_pkg::FMT_OFS, 32'h00000000);
        rd(serial_pkg::TXB_OFS, 32'h000000FF);
        rd(serial_pkg::RXB_OFS, 32'h00000000);
        wr(serial_pkg::RXB_OFS, 8'h5A);
        rd(serial_pkg::RXB_OFS, 32'h00000000);
        wr(serial_pkg::FMT_OFS, 8'h5A);
        rd(serial_pkg::FMT_OFS, 32'h0000005A);
        wr(serial_pkg::TXB_OFS, 8'h3C);
        rd(serial_pkg::TXB_OFS, 32'h0000003C);
        apb(1'b0, 8'h18, 32'h00000000, r);
        check({31'h00000000, last_err}, 32'h00000001);
        for (int i = 0; i < 10; i++) tx_case(tx_table[i]);
        // Synchronous frames also clocked in the idle-high line
        rd(serial_pkg::RXB_OFS, 32'h000000FF);
        rx_case(8'h00, 8'h00, 8'h3C, 8'h02);
        rx_case(8'h40, 8'h40, 8'hD5, 8'h02);
        rx_case(8'h20, 8'h30, 8'h07, 8'h0A);
        rx_case(8'h20, 8'h20, 8'h07, 8'h02);
        // One stop bit sent while two are set: next start follows at once
        n = mk(8'h00, 8'h00, 8'h81, v);
        k = mk(8'h00, 8'h00, 8'h42, w);
        wr(serial_pkg::FMT_OFS, 8'h08);
        wr(serial_pkg::FLG_OFS, 8'h00);
        fork
            peer_u.send(({16'h0000, w} << (n - 1)) | {16'h0000, v},
                        n + k - 2, 4);
            begin
                poll(serial_pkg::FLG_RDRF);
                rd(serial_pkg::RXB_OFS, 32'h00000081);
                wr(serial_pkg::FLG_OFS, 8'h00);
                poll(serial_pkg::FLG_RDRF);
                rd(serial_pkg::RXB_OFS, 32'h00000042);
            end
        join
        low_power_stop <= 1'b1;
        @(posedge pclk);
        low_power_stop <= 1'b0;
        @(posedge pclk);
        rd(serial_pkg::FMT_OFS, 32'h00000000);
        rd(serial_pkg::TXB_OFS, 32'h000000FF);
        rd(serial_pkg::RXB_OFS, 32'h00000000);
        report_and_stop();
    end
endmodule
